// ---- uss_pkg.sv ----
// constants and carrier types for the serial status and control block
package uss_pkg;
    // ======================================================================
    // register indices; byte address is four times the index
    // ======================================================================
    localparam logic [7:0] IDX_LINE_FLAGS = 8'h25;
    localparam logic [7:0] IDX_HANDSHAKE = 8'h26;
    localparam logic [7:0] IDX_CONTROL = 8'h27;
    localparam logic [7:0] IDX_EXT_STATUS = 8'h28;

    // ======================================================================
    // field positions
    // ======================================================================
    localparam int LF_OVERRUN = 1;
    localparam int LF_PARITY = 2;
    localparam int LF_FRAMING = 3;
    localparam int LF_BREAK = 4;
    localparam int LF_TX_LOW = 5;
    localparam int LF_SHIFT_EMPTY = 6;
    localparam int LF_SPECIAL = 7;
    localparam int LF_RX_AVAIL = 0;
    localparam int HS_CTS_CHG = 0;
    localparam int HS_DSR_CHG = 1;
    localparam int HS_CTS_LVL = 4;
    localparam int HS_DSR_LVL = 5;
    localparam int ES_TIMEOUT = 0;
    localparam int ES_PAR_HEAD = 1;
    localparam int ES_SPC_HEAD = 2;
    localparam int ES_RX_THR = 3;
    localparam int ES_TX_SPACE = 4;
    localparam int ES_RX_ON = 7;
    localparam int CT_SOFT_RST = 7;

    // ======================================================================
    // reset values, bus codes and timing counts
    // ======================================================================
    localparam logic [1:0] TX_THR_RESET = 2'h0;
    localparam logic [1:0] RX_THR_RESET = 2'h3;
    localparam logic [1:0] RX_THR_CODE_FOUR = 2'h0;
    localparam logic [2:0] RX_THR_FOUR = 3'h4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] SRST_CYCLES = 2'h2;
    localparam logic [4:0] OVERSAMPLE = 5'h10;
    localparam int RX_TIMEOUT_CLKS = 2048;

    // receiver events from the shift datapath, one-cycle pulses
    typedef struct packed {
        logic char_done;
        logic special;
        logic parity_bad;
        logic framing_bad;
        logic break_det;
        logic overrun;
    } uss_rx_evt_t;

    // control fields handed to the datapath
    typedef struct packed {
        logic soft_reset;
        logic [1:0] tx_thr;
        logic [1:0] rx_thr;
        logic sync_mode;
        logic tx_clk_int;
        logic rx_clk_int;
    } uss_ctrl_t;
endpackage : uss_pkg

// ---- uss_sticky_flag.sv ----
// sticky status flag: hardware set beats software clear
`timescale 1ns/1ps
module uss_sticky_flag (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic srst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic q_ff;

    // ======================================================================
    // flag storage
    // ======================================================================
    // set tested before clr so an event in the clearing cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff <= 1'b0;
        end else if (srst) begin
            q_ff <= 1'b0;
        end else if (set) begin
            q_ff <= 1'b1;
        end else if (clr) begin
            q_ff <= 1'b0;
        end
    end
    assign q = q_ff;

    // ======================================================================
    // checks
    // ======================================================================
    AST_FLAG_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
        (set && !srst) |=> q) else $error("flag lost a set event");
    AST_FLAG_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        (clr && !set) |=> !q) else $error("flag not cleared");
endmodule : uss_sticky_flag

// ---- uss_status_control.sv ----
// serial transceiver status and control registers on an ahb-lite slave
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module uss_status_control #(
    parameter int TX_DEPTH = 4,
    parameter int RX_DEPTH = 4,
    parameter int TIMEOUT_CLKS = uss_pkg::RX_TIMEOUT_CLKS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire uss_pkg::uss_rx_evt_t rx_evt,
    input wire logic [2:0] rx_count,
    input wire logic rx_pop,
    input wire logic rx_head_special,
    input wire logic rx_head_parity,
    input wire logic [2:0] tx_level,
    input wire logic tx_shift_empty,
    input wire logic dsr_n,
    input wire logic cts_n,
    input wire logic div_tick,
    input wire logic external_receive_clock_pin,
    output uss_pkg::uss_ctrl_t ctrl,
    output logic receiver_on,
    output logic rx_push,
    output logic tx_sample_tick,
    output logic rx_sample_tick,
    output logic tx_bit_tick,
    output logic rx_bit_tick
);
    localparam int TO_W = $clog2(TIMEOUT_CLKS + 1);

    initial begin
        if (TX_DEPTH < 1 || TX_DEPTH > 7 || RX_DEPTH < 4 || RX_DEPTH > 7)
            $error("queue depths outside the 3-bit level range");
        if (TIMEOUT_CLKS < 2)
            $error("timeout count too small");
    end

    // ======================================================================
    // ahb-lite address phase
    // ======================================================================
    logic acc;
    logic rd_acc;
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic [7:0] idx;
    logic rd_line;
    logic rd_hs;
    logic rd_ext;
    logic [7:0] rd_val;
    logic [31:0] hrdata_ff;

    // zero wait states: every transfer finishes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc = hsel && hready && (htrans == uss_pkg::HTRANS_NONSEQ);
    assign rd_acc = acc && !hwrite;
    assign idx = haddr[9:2];
    assign rd_line = rd_acc && (idx == uss_pkg::IDX_LINE_FLAGS);
    assign rd_hs = rd_acc && (idx == uss_pkg::IDX_HANDSHAKE);
    assign rd_ext = rd_acc && (idx == uss_pkg::IDX_EXT_STATUS);

    // write address held for the data phase where hwdata arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
        end else begin
            wr_pend_ff <= acc && hwrite;
            wr_idx_ff <= idx;
        end
    end

    // ======================================================================
    // software reset sequencer
    // ======================================================================
    logic [1:0] srst_cnt_ff;
    logic srst;
    logic wr_ctrl;
    logic wr_ext;

    assign wr_ctrl = wr_pend_ff && (wr_idx_ff == uss_pkg::IDX_CONTROL);
    assign wr_ext = wr_pend_ff && (wr_idx_ff == uss_pkg::IDX_EXT_STATUS);
    assign srst = (srst_cnt_ff != 2'h0);

    // two-cycle reset window, then the bit reads back zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            srst_cnt_ff <= 2'h0;
        end else if (srst) begin
            srst_cnt_ff <= srst_cnt_ff - 2'h1;
        end else if (wr_ctrl && hwdata[uss_pkg::CT_SOFT_RST]) begin
            srst_cnt_ff <= uss_pkg::SRST_CYCLES;
        end
    end

    // ======================================================================
    // control and receiver enable registers
    // ======================================================================
    logic [1:0] tx_thr_ff;
    logic [1:0] rx_thr_ff;
    logic sync_ff;
    logic tx_int_ff;
    logic rx_int_ff;
    logic rx_on_ff;

    // soft reset restores the same values as the hardware reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_thr_ff <= uss_pkg::TX_THR_RESET;
            rx_thr_ff <= uss_pkg::RX_THR_RESET;
            sync_ff <= 1'b0;
            tx_int_ff <= 1'b0;
            rx_int_ff <= 1'b0;
        end else if (srst) begin
            tx_thr_ff <= uss_pkg::TX_THR_RESET;
            rx_thr_ff <= uss_pkg::RX_THR_RESET;
            sync_ff <= 1'b0;
            tx_int_ff <= 1'b0;
            rx_int_ff <= 1'b0;
        end else if (wr_ctrl) begin
            tx_thr_ff <= hwdata[6:5];
            rx_thr_ff <= hwdata[4:3];
            sync_ff <= hwdata[2];
            tx_int_ff <= hwdata[1];
            rx_int_ff <= hwdata[0];
        end
    end

    // only bit 7 of the extended status register takes writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_on_ff <= 1'b0;
        end else if (srst) begin
            rx_on_ff <= 1'b0;
        end else if (wr_ext) begin
            rx_on_ff <= hwdata[uss_pkg::ES_RX_ON];
        end
    end

    assign ctrl = '{soft_reset: srst, tx_thr: tx_thr_ff, rx_thr: rx_thr_ff,
                    sync_mode: sync_ff, tx_clk_int: tx_int_ff,
                    rx_clk_int: rx_int_ff};
    assign receiver_on = rx_on_ff;

    // ======================================================================
    // clock source selection and bit timing
    // ======================================================================
    logic ext_clk_ff;
    logic ext_edge;
    logic [3:0] tx_os_ff;
    logic [3:0] rx_os_ff;
    logic [3:0] os_last;

    assign os_last = 4'(uss_pkg::OVERSAMPLE - 5'h01);

    // pin is synchronous; rising edge acts as one source clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_clk_ff <= 1'b0;
        end else begin
            ext_clk_ff <= external_receive_clock_pin;
        end
    end
    assign ext_edge = external_receive_clock_pin && !ext_clk_ff;
    assign tx_sample_tick = tx_int_ff ? div_tick : ext_edge;
    assign rx_sample_tick = rx_int_ff ? div_tick : ext_edge;

    // async: one bit per sixteen samples; sync: one bit per clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_os_ff <= 4'h0;
            rx_os_ff <= 4'h0;
        end else if (srst || sync_ff) begin
            tx_os_ff <= 4'h0;
            rx_os_ff <= 4'h0;
        end else begin
            if (tx_sample_tick) begin
                tx_os_ff <= (tx_os_ff == os_last) ? 4'h0 : tx_os_ff + 4'h1;
            end
            if (rx_sample_tick) begin
                rx_os_ff <= (rx_os_ff == os_last) ? 4'h0 : rx_os_ff + 4'h1;
            end
        end
    end
    assign tx_bit_tick = tx_sample_tick && (sync_ff || tx_os_ff == os_last);
    assign rx_bit_tick = rx_sample_tick && (sync_ff || rx_os_ff == os_last);

    // ======================================================================
    // receive event flags, cleared by a line flag read
    // ======================================================================
    logic [5:0] lf_set;
    logic [5:0] lf_q;
    logic rx_live;

    // a disabled receiver reports nothing and loads nothing
    assign rx_live = rx_on_ff && !srst;
    assign rx_push = rx_live && rx_evt.char_done && !rx_evt.framing_bad;
    assign lf_set[0] = rx_live && rx_evt.overrun;
    assign lf_set[1] = rx_push && rx_evt.parity_bad;
    assign lf_set[2] = rx_live && rx_evt.char_done && rx_evt.framing_bad;
    assign lf_set[3] = rx_live && rx_evt.break_det;
    assign lf_set[4] = rx_push && rx_evt.special;
    // handshake change detectors
    logic dsr_n_ff;
    logic cts_n_ff;
    assign lf_set[5] = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dsr_n_ff <= 1'b1;
            cts_n_ff <= 1'b1;
        end else begin
            dsr_n_ff <= dsr_n;
            cts_n_ff <= cts_n;
        end
    end

    // ======================================================================
    // timeout on an idle, under-threshold receive queue
    // ======================================================================
    logic [2:0] rx_thr_bytes;
    logic rx_at_thr;
    logic to_armed;
    logic to_set;
    logic [TO_W-1:0] to_cnt_ff;

    assign rx_thr_bytes = (rx_thr_ff == uss_pkg::RX_THR_CODE_FOUR) ?
        uss_pkg::RX_THR_FOUR : {1'b0, rx_thr_ff};
    assign rx_at_thr = (rx_count >= rx_thr_bytes);
    assign to_armed = !rx_at_thr && (rx_count != 3'h0);
    assign to_set = to_armed && rx_sample_tick &&
        (to_cnt_ff == TO_W'(TIMEOUT_CLKS - 1));

    // counts receiver clocks since the last character; saturates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            to_cnt_ff <= '0;
        end else if (srst || !to_armed || rx_evt.char_done) begin
            to_cnt_ff <= '0;
        end else if (rx_sample_tick && to_cnt_ff != TO_W'(TIMEOUT_CLKS)) begin
            to_cnt_ff <= to_cnt_ff + TO_W'(1);
        end
    end

    // ======================================================================
    // sticky flag cells
    // ======================================================================
    logic [7:0] fl_set;
    logic [7:0] fl_clr;
    logic [7:0] fl_q;

    // cells 0-4 line flags, 5-6 handshake changes, 7 timeout
    assign fl_set = {to_set, dsr_n != dsr_n_ff, cts_n != cts_n_ff, lf_set[4:0]};
    assign fl_clr = {rd_ext || (rx_count == 3'h0), rd_hs, rd_hs, {5{rd_line}}};
    assign lf_q = {1'b0, fl_q[4:0]};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            uss_sticky_flag u_flag (
                .hclk(hclk),
                .hresetn(hresetn),
                .srst(srst),
                .set(fl_set[gi]),
                .clr(fl_clr[gi]),
                .q(fl_q[gi])
            );
        end
    endgenerate

    // ======================================================================
    // read data
    // ======================================================================
    logic [7:0] line_val;
    logic [7:0] hs_val;
    logic [7:0] ctrl_val;
    logic [7:0] ext_val;
    logic tx_low;

    assign tx_low = (tx_level <= {1'b0, tx_thr_ff});
    always_comb begin
        line_val = 8'h00;
        line_val[uss_pkg::LF_SPECIAL] = lf_q[4];
        line_val[uss_pkg::LF_SHIFT_EMPTY] = tx_shift_empty;
        line_val[uss_pkg::LF_TX_LOW] = tx_low;
        line_val[uss_pkg::LF_BREAK] = lf_q[3];
        line_val[uss_pkg::LF_FRAMING] = lf_q[2];
        line_val[uss_pkg::LF_PARITY] = lf_q[1];
        line_val[uss_pkg::LF_OVERRUN] = lf_q[0];
        line_val[uss_pkg::LF_RX_AVAIL] = (rx_count != 3'h0);
        hs_val = 8'h00;
        hs_val[uss_pkg::HS_DSR_LVL] = !dsr_n;
        hs_val[uss_pkg::HS_CTS_LVL] = !cts_n;
        hs_val[uss_pkg::HS_DSR_CHG] = fl_q[6];
        hs_val[uss_pkg::HS_CTS_CHG] = fl_q[5];
        ctrl_val = {srst, tx_thr_ff, rx_thr_ff, sync_ff, tx_int_ff, rx_int_ff};
        ext_val = 8'h00;
        ext_val[uss_pkg::ES_RX_ON] = rx_on_ff;
        ext_val[uss_pkg::ES_TX_SPACE] = (tx_level < 3'(TX_DEPTH));
        ext_val[uss_pkg::ES_RX_THR] = rx_at_thr;
        ext_val[uss_pkg::ES_SPC_HEAD] = rx_head_special && (rx_count != 3'h0);
        ext_val[uss_pkg::ES_PAR_HEAD] = rx_head_parity && (rx_count != 3'h0);
        ext_val[uss_pkg::ES_TIMEOUT] = fl_q[7];
        unique case (idx)
            uss_pkg::IDX_LINE_FLAGS: rd_val = line_val;
            uss_pkg::IDX_HANDSHAKE: rd_val = hs_val;
            uss_pkg::IDX_CONTROL: rd_val = ctrl_val;
            uss_pkg::IDX_EXT_STATUS: rd_val = ext_val;
            default: rd_val = 8'h00;
        endcase
    end

    // value captured at the address edge, before its flags clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_acc) begin
            hrdata_ff <= {24'h00_0000, rd_val};
        end
    end
    assign hrdata = hrdata_ff;

    // ======================================================================
    // checks
    // ======================================================================
    AST_LINE_READ_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_line && lf_set == 6'h00 && !srst) |=> (lf_q[4:0] == 5'h00))
        else $error("line flags survived a read");
    AST_SPECIAL_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_push && rx_evt.special && !srst) |=> lf_q[4])
        else $error("special flag not set");
    AST_FRAMING_DROPS: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_evt.framing_bad) |-> !rx_push)
        else $error("framed-bad character loaded");
    AST_SRST_TWO: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(srst) |-> srst ##1 srst ##1 !srst)
        else $error("soft reset not two cycles");
    AST_SRST_DEFAULTS: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(srst) |-> (rx_thr_ff == uss_pkg::RX_THR_RESET && !rx_on_ff))
        else $error("soft reset left state");
    AST_RX_THR_FOUR: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_thr_ff == 2'h0 && rx_count == 3'h3) |-> !rx_at_thr)
        else $error("code 00 not four bytes");
    AST_SYNC_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
        sync_ff |-> (rx_bit_tick == rx_sample_tick))
        else $error("sync mode not one bit per clock");
    AST_TIMEOUT_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
        (to_set && !srst) |=> fl_q[7])
        else $error("timeout not flagged");
    AST_HS_CHANGE: assert property (@(posedge hclk) disable iff (!hresetn)
        ($changed(dsr_n) && !srst) |=> fl_q[6])
        else $error("dsr change missed");
    COV_SRST: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(srst));
    COV_TIMEOUT: cover property (@(posedge hclk) disable iff (!hresetn)
        to_set);
    COV_SET_CLR: cover property (@(posedge hclk) disable iff (!hresetn)
        rd_line && lf_set != 6'h00);
endmodule : uss_status_control

// ---- uss_far_end.sv ----
// far-side model: receive datapath events and serial clock sources
`timescale 1ns/1ps
module uss_far_end (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire uss_pkg::uss_rx_evt_t req,
    output uss_pkg::uss_rx_evt_t rx_evt,
    output logic div_tick,
    output logic ext_clk
);
    uss_pkg::uss_rx_evt_t evt_ff;
    logic [1:0] div_ff;
    logic pin_ff;
    // ==========
    // events last one cycle, as the datapath would raise them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_ff <= 6'h0;
        end else begin
            evt_ff <= req;
        end
    end
    // clocks stand still outside a burst so idle counts hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 2'h0;
            pin_ff <= 1'b0;
        end else begin
            div_ff <= run ? div_ff + 2'h1 : 2'h0;
            pin_ff <= run ? ~pin_ff : 1'b0;
        end
    end
    assign rx_evt = evt_ff;
    assign div_tick = run && (div_ff == 2'h3);
    assign ext_clk = pin_ff;
endmodule : uss_far_end

// ---- usart_status_control_test.sv ----
// self-checking bench for the serial status and control block
`timescale 1ns/1ps
module usart_status_control_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, run = 1'b0, dph = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h14823;
    logic [1:0] htrans = 2'h0;
    logic [2:0] rx_count = 3'h0, tx_level = 3'h0, lv, cnt, thr4;
    logic hspc = 1'b0, hpar = 1'b0, sh_empty = 1'b1;
    logic dsr_n = 1'b1, cts_n = 1'b1;
    logic hreadyout, hresp, receiver_on, div_tick, ext_clk;
    uss_pkg::uss_rx_evt_t req = 6'h0, rx_evt;
    uss_pkg::uss_ctrl_t ctrl;
    logic [7:0] q[$];
    logic [31:0] r;
    int failures = 0, checks_done = 0;
    always #2.5 hclk = ~hclk;
    uss_status_control #(.TIMEOUT_CLKS(8)) uss_status_control_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rx_evt(rx_evt), .rx_count(rx_count),
        .rx_pop(1'b0), .rx_head_special(hspc), .rx_head_parity(hpar),
        .tx_level(tx_level), .tx_shift_empty(sh_empty), .dsr_n(dsr_n),
        .cts_n(cts_n), .div_tick(div_tick),
        .external_receive_clock_pin(ext_clk), .ctrl(ctrl),
        .receiver_on(receiver_on), .rx_push(), .tx_sample_tick(),
        .rx_sample_tick(), .tx_bit_tick(), .rx_bit_tick());
    uss_far_end uss_far_end_i (.hclk(hclk), .hresetn(hresetn), .run(run),
        .req(req), .rx_evt(rx_evt), .div_tick(div_tick), .ext_clk(ext_clk));
    // ==========
    // helpers
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one transfer; a read notes its expected byte for the monitor
    task ahb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= uss_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        if (!w) q.push_back(d);
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask : ahb
    task evt(input logic [5:0] e);
        req <= e;
        @(posedge hclk);
        req <= 6'h0;
        repeat (2) @(posedge hclk);
    endtask : evt
    task wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // ==========
    // monitor: read data stands in the cycle after its address phase
    always @(posedge hclk) begin
        if (dph) chk(hrdata, {24'h0, q.pop_front()});
        dph <= hsel && htrans == uss_pkg::HTRANS_NONSEQ && !hwrite;
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        wrap_up();
    end
    // ==========
    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, uss_pkg::IDX_LINE_FLAGS, 8'h60);
        ahb(0, uss_pkg::IDX_HANDSHAKE, 8'h00);
        ahb(0, uss_pkg::IDX_CONTROL, 8'h18);
        ahb(0, uss_pkg::IDX_EXT_STATUS, 8'h10);
        ahb(0, 8'h30, 8'h00);
        ahb(1, uss_pkg::IDX_LINE_FLAGS, 8'hff);
        ahb(0, uss_pkg::IDX_LINE_FLAGS, 8'h60);
        ahb(1, uss_pkg::IDX_EXT_STATUS, 8'hff);
        ahb(0, uss_pkg::IDX_EXT_STATUS, 8'h90);
        chk({31'h0, receiver_on}, 32'h1);
        chk({24'h0, ctrl}, 32'h18);
        $display("done: reset and access");
        // overrun, break, framing, parity, special, each with a character
        foreach (r[i]) if (i < 5) evt(6'h20 | (6'h10 >> i));
        ahb(0, uss_pkg::IDX_LINE_FLAGS, 8'hfe);
        ahb(0, uss_pkg::IDX_LINE_FLAGS, 8'h60);
        cts_n <= 1'b0;
        repeat (2) @(posedge hclk);
        ahb(0, uss_pkg::IDX_HANDSHAKE, 8'h11);
        dsr_n <= 1'b0;
        // let the change register before the read that should report it
        @(posedge hclk);
        ahb(0, uss_pkg::IDX_HANDSHAKE, 8'h32);
        ahb(0, uss_pkg::IDX_HANDSHAKE, 8'h30);
        $display("done: events");
        // random thresholds against random queue levels
        repeat (12) begin
            r = xs();
            lv = (r[6:4] > 3'h4) ? 3'h4 : r[6:4];
            cnt = (r[9:7] > 3'h4) ? 3'h4 : r[9:7];
            thr4 = (r[3:2] == 2'h0) ? uss_pkg::RX_THR_FOUR : {1'b0, r[3:2]};
            tx_level <= lv;
            rx_count <= cnt;
            sh_empty <= r[10];
            ahb(1, uss_pkg::IDX_CONTROL, {3'h0, r[1:0], r[3:2], 3'h0});
            ahb(0, uss_pkg::IDX_CONTROL, {3'h0, r[1:0], r[3:2], 3'h0});
            ahb(0, uss_pkg::IDX_LINE_FLAGS, {1'b0, r[10], lv <= r[1:0],
                4'h0, cnt != 3'h0});
            ahb(0, uss_pkg::IDX_EXT_STATUS, {3'h4, lv < 3'h4,
                cnt >= thr4, 3'h0});
        end
        $display("done: thresholds");
        tx_level <= 3'h0;
        rx_count <= 3'h1;
        sh_empty <= 1'b1;
        {hspc, hpar} <= 2'h3;
        ahb(1, uss_pkg::IDX_CONTROL, 8'h18);
        run <= 1'b1;
        repeat (40) @(posedge hclk);
        run <= 1'b0;
        @(posedge hclk);
        ahb(0, uss_pkg::IDX_EXT_STATUS, 8'h97);
        ahb(0, uss_pkg::IDX_EXT_STATUS, 8'h96);
        ahb(1, uss_pkg::IDX_CONTROL, 8'h9f);
        repeat (4) @(posedge hclk);
        ahb(0, uss_pkg::IDX_CONTROL, 8'h18);
        ahb(0, uss_pkg::IDX_EXT_STATUS, 8'h16);
        ahb(0, uss_pkg::IDX_LINE_FLAGS, 8'h61);
        $display("done: timeout and soft reset");
        wrap_up();
    end
endmodule : usart_status_control_test
